// *** src/ut_pkg.sv ***
package ut_pkg;
    // Register offsets on the plain register port
    localparam logic [3:0] A_DATA = 4'h0;
    localparam logic [3:0] A_IER = 4'h1;
    localparam logic [3:0] A_FCR = 4'h2;
    localparam logic [3:0] A_LCR = 4'h3;
    localparam logic [3:0] A_MCR = 4'h4;
    localparam logic [3:0] A_LSR = 4'h5;
    localparam logic [3:0] A_EFR = 4'h6;
    localparam logic [3:0] A_DLD = 4'h7;
    localparam logic [3:0] A_ISR = 4'h8;
    // Field positions
    localparam int B_FIFO_EN = 0;
    localparam int B_RTS = 1;
    localparam int B_STOP2 = 2;
    localparam int B_PAR_EN = 3;
    localparam int B_PAR_EVEN = 4;
    localparam int B_IER_RX = 0;
    localparam int B_IER_TX = 1;
    localparam int B_IER_RTS = 6;
    localparam int B_IER_CTS = 7;
    localparam int B_EFR_ENH = 4;
    localparam int B_EFR_ARTS = 6;
    localparam int B_EFR_ACTS = 7;
    // Depths, word length base and timeout figures
    localparam logic [6:0] FIFO_DEPTH = 7'h40;
    localparam logic [3:0] WLEN_BASE = 4'h5;
    localparam logic [9:0] TO_CHARS = 10'h004;
    localparam logic [9:0] TO_EXTRA = 10'h00C;
    // Receive trigger steps
    localparam logic [6:0] LVL_0 = 7'h00;
    localparam logic [6:0] LVL_8 = 7'h08;
    localparam logic [6:0] LVL_16 = 7'h10;
    localparam logic [6:0] LVL_56 = 7'h38;
    localparam logic [6:0] LVL_60 = 7'h3C;
    // Bit period minus one for 16X, 8X and 4X
    localparam logic [3:0] OVS16_M1 = 4'hF;
    localparam logic [3:0] OVS8_M1 = 4'h7;
    localparam logic [3:0] OVS4_M1 = 4'h3;
    // Register reset values
    localparam logic [7:0] REG_RST = 8'h00;

    typedef enum logic [2:0] {
        TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP
    } ut_tx_st_t;

    typedef enum logic [2:0] {
        RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP
    } ut_rx_st_t;
endpackage

// *** src/ut_core.sv ***
`timescale 1ns/10ps
// Notes on behaviour
// RULE1 - Transmitter sends one bit every 16, 8 or 4 oversampling ticks.
// RULE2 - Frame: start, data bits, optional parity, then one or two stops.
// RULE3 - Data bits leave least significant bit first.
// RULE4 - In FIFO mode each holding write pushes into a 64-byte queue.
// RULE5 - Without FIFO, holding-empty sets when byte moves to the shifter.
// RULE6 - With FIFO, holding-empty is set whenever the queue is empty.
// RULE7 - Holding-empty becoming set raises transmit-empty interrupt if enabled.
// RULE8 - Transmitter-empty only when shifter and queue are both empty.
// RULE9 - Falling edge, wait half a bit, accept start only if still low.
// RULE10 - Later bits are sampled at their centres, one bit period apart.
// RULE11 - Receive queue holds 64 entries of data plus three error tags.
// RULE12 - Reading received data pops queue; status shows new head tags.
// RULE13 - Data-ready interrupt per character, or at trigger level in FIFO.
// RULE14 - Timeout when data waits four word lengths plus 12 bit times.
// RULE15 - Auto request-to-send needs enable bit and software asserting it.
// RULE16 - Request-to-send rising sets flow flag when its enable is set.
// RULE17 - Request-to-send goes high one step above trigger, low one below.
// RULE18 - Thresholds: 8:16/0, 16:56/8, 56:60/16, 60:60/56.
// RULE19 - Reception continues after request-to-send off until queue full.
// RULE20 - Auto clear-to-send enable; clear-to-send rising sets flow flag.
// RULE21 - Clear-to-send high stops transmitter after current stop bit.
// RULE22 - Remote side stops after its current character when told to.
// RULE23 - Sampling mode bits select 16X, 8X or 4X.
// RULE24 - Word length is 5 to 8 bits from two line control bits.
// RULE25 - A high mid-start sample is dropped and receiver returns idle.
// RULE26 - Suspended transmit queue is kept and still accepts writes.
module ut_core
    import ut_pkg::*;
(
    // Clock and reset
    input wire logic CLK_I,
    input wire logic RST_N_I,
    // Oversampling tick from the rate generator
    input wire logic BAUD_TICK_I,
    // Register port
    input wire logic [3:0] ADDR_I,
    input wire logic [7:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [7:0] RDATA_O,
    // Serial link
    input wire logic RXD_I,
    input wire logic CTS_N_I,
    output logic TXD_O,
    output logic RTS_N_O,
    // Interrupt
    output logic IRQ_O
);
    typedef struct packed {
        logic [63:0][7:0] txf;
        logic [5:0] txw;
        logic [5:0] txr;
        logic [6:0] txc;
        logic [63:0][10:0] rxf;
        logic [5:0] rxw;
        logic [5:0] rxr;
        logic [6:0] rxc;
        logic [7:0] interrupt_enable;
        logic [7:0] fifo_control;
        logic [7:0] line_control;
        logic [7:0] modem_control;
        logic [7:0] enhanced_feature;
        logic [7:0] fractional_divisor;
        ut_tx_st_t tx_st;
        logic [3:0] tx_ph;
        logic [7:0] tx_sh;
        logic [2:0] tx_bi;
        logic tx_pb;
        logic tx_sb;
        ut_rx_st_t rx_st;
        logic [3:0] rx_ph;
        logic [7:0] rx_sh;
        logic [2:0] rx_bi;
        logic rx_pe;
        logic rx_prev;
        logic cts_prev;
        logic [9:0] to_cnt;
        logic to_flag;
        logic txe_flag;
        logic fc_flag;
        logic rts_off;
        logic ovr;
        logic tx_o;
        logic rts_n_o;
        logic irq_o;
        logic [7:0] rd_data;
    } ut_state_t;

    ut_state_t s;
    ut_state_t n;
    logic rst_meta;
    logic rst_n;
    logic [3:0] ovs_m1;
    logic [3:0] half_m1;
    logic [3:0] wlen;
    logic [9:0] to_lim;
    logic [6:0] trig;
    logic [6:0] rts_hi;
    logic [6:0] rts_lo;
    logic fifo_en;
    logic tx_full;
    logic rx_full;
    logic wr_thr;
    logic rd_rhr;
    logic rd_isr;
    logic rd_lsr;
    logic tx_pop;
    logic rx_push;
    logic rx_pop;
    logic bit_end;
    logic rx_rdy;
    logic irq_any;
    logic [7:0] line_status;
    logic [7:0] interrupt_status;

    // Parity over the active data bits
    function automatic logic par_of(input logic [7:0] d,
                                    input logic [3:0] wl,
                                    input logic even);
        logic [7:0] m;
        logic p;
        m = 8'hFF >> (4'h8 - wl);
        p = ^(d & m);
        return even ? p : ~p;
    endfunction

    // Reset release through two flip-flops
    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Mode decode
    always_comb begin
        case (s.fractional_divisor[5:4]) // [RULE23]
            2'b01: ovs_m1 = OVS8_M1;
            2'b10: ovs_m1 = OVS4_M1;
            default: ovs_m1 = OVS16_M1;
        endcase
        half_m1 = ovs_m1 >> 1;
        wlen = WLEN_BASE + {2'b00, s.line_control[1:0]}; // [RULE24]
        to_lim = 10'((10'(wlen) * TO_CHARS + TO_EXTRA)
                 * (10'(ovs_m1) + 10'h001)); // [RULE14]
        case (s.fifo_control[7:6]) // [RULE18]
            2'b00: begin
                trig = LVL_8;
                rts_hi = LVL_16;
                rts_lo = LVL_0;
            end
            2'b01: begin
                trig = LVL_16;
                rts_hi = LVL_56;
                rts_lo = LVL_8;
            end
            2'b10: begin
                trig = LVL_56;
                rts_hi = LVL_60;
                rts_lo = LVL_16;
            end
            default: begin
                trig = LVL_60;
                rts_hi = LVL_60;
                rts_lo = LVL_56;
            end
        endcase
    end

    // Status views and access decode
    always_comb begin
        fifo_en = s.fifo_control[B_FIFO_EN];
        tx_full = fifo_en ? (s.txc == FIFO_DEPTH) : (s.txc != 7'h00);
        rx_full = fifo_en ? (s.rxc == FIFO_DEPTH) : (s.rxc != 7'h00);
        wr_thr = WR_I && (ADDR_I == A_DATA);
        rd_rhr = RD_I && (ADDR_I == A_DATA);
        rd_isr = RD_I && (ADDR_I == A_ISR);
        rd_lsr = RD_I && (ADDR_I == A_LSR);
        rx_pop = rd_rhr && (s.rxc != 7'h00);
        rx_rdy = fifo_en ? (s.rxc >= trig) : (s.rxc != 7'h00); // [RULE13]
        irq_any = (s.interrupt_enable[B_IER_RX] && (rx_rdy || s.to_flag))
                  || (s.interrupt_enable[B_IER_TX] && s.txe_flag) || s.fc_flag;
        line_status = {1'b0, (s.txc == 7'h00) && (s.tx_st == TX_IDLE), // [RULE8]
               s.txc == 7'h00, // [RULE5] [RULE6]
               (s.rxc != 7'h00) ? s.rxf[s.rxr][10:8] : 3'b000, // [RULE12]
               s.ovr, s.rxc != 7'h00};
        interrupt_status = {2'b00, s.fc_flag, 1'b0, s.to_flag,
               s.interrupt_enable[B_IER_RX] && rx_rdy, s.txe_flag, ~irq_any};
    end

    // Next-state logic
    always_comb begin
        n = s;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        bit_end = 1'b0;
        // Control register writes
        if (WR_I) begin
            case (ADDR_I)
                A_IER: n.interrupt_enable = WDATA_I;
                A_FCR: n.fifo_control = WDATA_I;
                A_LCR: n.line_control = WDATA_I;
                A_MCR: n.modem_control = WDATA_I;
                A_EFR: n.enhanced_feature = WDATA_I;
                A_DLD: n.fractional_divisor = WDATA_I;
                default: n.interrupt_enable = s.interrupt_enable;
            endcase
        end
        // Holding write; accepted even while suspended
        if (wr_thr && !tx_full) begin // [RULE4] [RULE26]
            n.txf[s.txw] = WDATA_I;
            n.txw = s.txw + 6'h01;
        end
        // Transmitter
        if (s.tx_st == TX_IDLE) begin
            if (s.txc != 7'h00
                && !(s.enhanced_feature[B_EFR_ACTS] && CTS_N_I)) begin // [RULE21]
                n.tx_sh = s.txf[s.txr];
                n.tx_pb = par_of(s.txf[s.txr], wlen, s.line_control[B_PAR_EVEN]);
                n.txr = s.txr + 6'h01;
                tx_pop = 1'b1;
                n.tx_st = TX_START;
                n.tx_ph = 4'h0;
                n.tx_sb = 1'b0;
            end
        end else if (BAUD_TICK_I) begin
            if (s.tx_ph == ovs_m1) begin // [RULE1]
                n.tx_ph = 4'h0;
                bit_end = 1'b1;
            end else begin
                n.tx_ph = s.tx_ph + 4'h1;
            end
        end
        // Bit sequencing of the frame
        if (bit_end) begin
            case (s.tx_st) // [RULE2]
                TX_START: begin
                    n.tx_st = TX_DATA;
                    n.tx_bi = 3'h0;
                end
                TX_DATA: begin
                    n.tx_sh = s.tx_sh >> 1; // [RULE3]
                    n.tx_bi = s.tx_bi + 3'h1;
                    if ({1'b0, s.tx_bi} == wlen - 4'h1) begin
                        n.tx_st = s.line_control[B_PAR_EN] ? TX_PAR : TX_STOP;
                    end
                end
                TX_PAR: n.tx_st = TX_STOP;
                TX_STOP: begin
                    if (s.line_control[B_STOP2] && !s.tx_sb) begin
                        n.tx_sb = 1'b1;
                    end else begin
                        n.tx_st = TX_IDLE;
                    end
                end
                default: n.tx_st = TX_IDLE;
            endcase
        end
        // Line level of the next state
        case (n.tx_st)
            TX_START: n.tx_o = 1'b0;
            TX_DATA: n.tx_o = n.tx_sh[0]; // [RULE3]
            TX_PAR: n.tx_o = n.tx_pb;
            default: n.tx_o = 1'b1;
        endcase
        n.txc = s.txc + {6'h00, wr_thr && !tx_full} - {6'h00, tx_pop};
        // Receiver
        n.rx_prev = RXD_I;
        if (s.rx_st == RX_IDLE) begin
            if (s.rx_prev && !RXD_I) begin // [RULE9]
                n.rx_st = RX_START;
                n.rx_ph = 4'h0;
            end
        end else if (BAUD_TICK_I) begin
            if (s.rx_st == RX_START) begin
                if (s.rx_ph == half_m1) begin // [RULE9]
                    n.rx_ph = 4'h0;
                    n.rx_bi = 3'h0;
                    n.rx_sh = 8'h00;
                    n.rx_pe = 1'b0;
                    n.rx_st = RXD_I ? RX_IDLE : RX_DATA; // [RULE25]
                end else begin
                    n.rx_ph = s.rx_ph + 4'h1;
                end
            end else if (s.rx_ph == ovs_m1) begin // [RULE10]
                n.rx_ph = 4'h0;
                case (s.rx_st)
                    RX_DATA: begin
                        n.rx_sh[s.rx_bi] = RXD_I;
                        n.rx_bi = s.rx_bi + 3'h1;
                        if ({1'b0, s.rx_bi} == wlen - 4'h1) begin
                            n.rx_st = s.line_control[B_PAR_EN] ? RX_PAR : RX_STOP;
                        end
                    end
                    RX_PAR: begin
                        n.rx_pe = RXD_I
                            != par_of(s.rx_sh, wlen, s.line_control[B_PAR_EVEN]);
                        n.rx_st = RX_STOP;
                    end
                    default: begin
                        rx_push = 1'b1;
                        n.rx_st = RX_IDLE;
                    end
                endcase
            end else begin
                n.rx_ph = s.rx_ph + 4'h1;
            end
        end
        // Store character with its tags; still filling when flow is off
        if (rx_push && !rx_full) begin // [RULE11] [RULE19]
            n.rxf[s.rxw] = {(s.rx_sh == 8'h00) && !RXD_I, !RXD_I,
                            s.rx_pe, s.rx_sh};
            n.rxw = s.rxw + 6'h01;
        end
        if (rx_pop) begin // [RULE12]
            n.rxr = s.rxr + 6'h01;
        end
        n.rxc = s.rxc + {6'h00, rx_push && !rx_full} - {6'h00, rx_pop};
        n.ovr = (rx_push && rx_full) || (s.ovr && !rd_lsr);
        // Receive timeout
        if (rx_push || rd_rhr || s.rxc == 7'h00) begin
            n.to_cnt = 10'h000;
        end else if (BAUD_TICK_I && s.to_cnt != to_lim) begin
            n.to_cnt = s.to_cnt + 10'h001;
        end
        n.to_flag = ((s.to_cnt == to_lim) && s.rxc != 7'h00) // [RULE14]
                    || (s.to_flag && !(rd_rhr || rx_push));
        // Transmit-empty event, set wins over clear
        n.txe_flag = (s.txc != 7'h00 && n.txc == 7'h00) // [RULE7]
                     || (s.txe_flag && !(rd_isr || wr_thr));
        // Request-to-send hysteresis
        if (!s.enhanced_feature[B_EFR_ARTS]) begin
            n.rts_off = 1'b0;
        end else if (n.rxc >= rts_hi) begin // [RULE17]
            n.rts_off = 1'b1;
        end else if (n.rxc <= rts_lo) begin // [RULE17]
            n.rts_off = 1'b0;
        end
        n.rts_n_o = ~n.modem_control[B_RTS]
                    || (n.enhanced_feature[B_EFR_ARTS] && n.rts_off); // [RULE15]
        n.cts_prev = CTS_N_I;
        n.fc_flag = (s.interrupt_enable[B_IER_RTS] && s.enhanced_feature[B_EFR_ENH]
                     && !s.rts_n_o && n.rts_n_o) // [RULE16]
                    || (s.interrupt_enable[B_IER_CTS] && s.enhanced_feature[B_EFR_ENH]
                        && CTS_N_I && !s.cts_prev) // [RULE20]
                    || (s.fc_flag && !rd_isr);
        n.irq_o = irq_any;
        // Read data one cycle after the strobe
        n.rd_data = 8'h00;
        if (RD_I) begin
            case (ADDR_I)
                A_DATA: n.rd_data = s.rxf[s.rxr][7:0];
                A_IER: n.rd_data = s.interrupt_enable;
                A_FCR: n.rd_data = s.fifo_control;
                A_LCR: n.rd_data = s.line_control;
                A_MCR: n.rd_data = s.modem_control;
                A_LSR: n.rd_data = line_status;
                A_EFR: n.rd_data = s.enhanced_feature;
                A_DLD: n.rd_data = s.fractional_divisor;
                A_ISR: n.rd_data = interrupt_status;
                default: n.rd_data = 8'h00;
            endcase
        end
    end

    // State register
    always_ff @(posedge CLK_I or negedge rst_n) begin
        if (!rst_n) begin
            s <= '0;
            s.interrupt_enable <= REG_RST;
            s.tx_o <= 1'b1;
            s.rts_n_o <= 1'b1;
            s.rx_prev <= 1'b1;
            s.cts_prev <= 1'b1;
        end else begin
            s <= n;
        end
    end

    assign RDATA_O = s.rd_data;
    assign TXD_O = s.tx_o;
    assign RTS_N_O = s.rts_n_o;
    assign IRQ_O = s.irq_o;

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    chk_tx_start_low: assert property ( // [RULE2]
        s.tx_st == TX_START |-> !TXD_O)
        else $error("start bit not low");
    chk_tx_stop_high: assert property ( // [RULE2]
        s.tx_st == TX_STOP || s.tx_st == TX_IDLE |-> TXD_O)
        else $error("stop or idle not high");
    chk_tx_lsb_first: assert property ( // [RULE3]
        s.tx_st == TX_DATA |-> TXD_O == s.tx_sh[0])
        else $error("data bit out of order");
    chk_bit_period: assert property ( // [RULE1]
        s.tx_st != TX_IDLE && BAUD_TICK_I && s.tx_ph == ovs_m1
        |=> s.tx_ph == 4'h0)
        else $error("bit period wrong");
    chk_cts_hold: assert property ( // [RULE21]
        s.tx_st == TX_IDLE && s.enhanced_feature[B_EFR_ACTS] && CTS_N_I
        |=> s.tx_st == TX_IDLE && s.txc >= $past(s.txc))
        else $error("sent while clear-to-send high");
    chk_false_start: assert property ( // [RULE25]
        s.rx_st == RX_START && BAUD_TICK_I && s.rx_ph == half_m1
        && RXD_I |=> s.rx_st == RX_IDLE && s.rxc <= $past(s.rxc))
        else $error("false start accepted");
    chk_rts_high: assert property ( // [RULE17]
        s.enhanced_feature[B_EFR_ARTS] && s.modem_control[B_RTS] && n.rxc >= rts_hi
        |=> RTS_N_O)
        else $error("request-to-send not released");
    chk_rx_pop: assert property ( // [RULE12]
        rx_pop && !rx_push |=> s.rxc == $past(s.rxc) - 7'h01)
        else $error("receive queue not advanced");
    chk_temt_flag: assert property ( // [RULE8]
        line_status[6] |-> s.txc == 7'h00 && TXD_O)
        else $error("transmitter empty while busy");
endmodule

// *** testbench/ut_remote.sv ***
`timescale 1ns/10ps
module ut_remote (
    // Clock, reset and oversampling tick
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic tick_i,
    // Frame format: ticks per bit, data bits, parity on
    input wire logic [4:0] ovs_i,
    input wire logic [3:0] len_i,
    input wire logic par_i,
    // Serial link seen from the far end
    input wire logic line_i,
    input wire logic cts_n_i,
    output logic line_o
);
    logic [8:0] txq[$];
    logic [7:0] rxq[$];
    logic [11:0] sh;
    logic [7:0] rd;
    logic rp;
    int tn;
    int tt;
    int rn;
    int rt;

    // Bit 8 of the entry spoils the parity bit
    function automatic logic [11:0] frame(input logic [8:0] v);
        logic [11:0] f;
        f = '1;
        for (int i = 0; i < len_i; i++) f[i] = v[i];
        if (par_i) f[len_i] = ^(v[7:0] & ((8'h01 << len_i) - 8'h01)) ^ v[8];
        return f;
    endfunction

    // Transmitter: a new frame starts only while clear-to-send is low
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_o <= 1'b1;
            tn <= 0;
        end else if (tn == 0) begin
            if (tick_i && !cts_n_i && txq.size() > 0) begin
                sh <= frame(txq.pop_front());
                tn <= 2 + len_i + par_i;
                tt <= 0;
                line_o <= 1'b0;
            end
        end else if (tick_i) begin
            tt <= (tt == ovs_i - 1) ? 0 : tt + 1;
            if (tt == ovs_i - 1) begin
                tn <= tn - 1;
                line_o <= (tn == 1) ? 1'b1 : sh[0];
                sh <= sh >> 1;
            end
        end
    end

    // Receiver: samples each bit in its centre, EE marks a bad frame
    always @(posedge clk_i) begin
        if (!rst_n_i) begin
            rn <= 0;
        end else if (rn == 0) begin
            if (!line_i) begin
                rn <= 1;
                rt <= 0;
                rd <= 8'h00;
            end
        end else if (tick_i) begin
            rt <= rt + 1;
            if (rt == ovs_i / 2 + (rn - 1) * ovs_i) begin
                rn <= rn + 1;
                if (rn >= 2 && rn <= len_i + 1) rd[rn - 2] <= line_i;
                if (par_i && rn == len_i + 2) rp <= line_i;
                if (rn == len_i + 2 + par_i) begin
                    rxq.push_back((!line_i || (par_i && ^rd != rp)) ?
                                  8'hEE : rd);
                    rn <= 0;
                end
            end
        end
    end
endmodule

// *** testbench/tb.sv ***
`timescale 1ns/10ps
module tb;
    import ut_pkg::*;
    logic clk;
    logic rst_n;
    logic tick;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic cts_n;
    logic glitch;
    logic [7:0] rdata;
    logic txd;
    logic rts_n;
    logic irq;
    logic rem_line;
    logic par;
    int ovs;
    int len;
    int n_fail;
    int tests_run;

    ut_core DUT (
        .CLK_I(clk), .RST_N_I(rst_n), .BAUD_TICK_I(tick),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd),
        .RDATA_O(rdata), .RXD_I(rem_line & ~glitch), .CTS_N_I(cts_n),
        .TXD_O(txd), .RTS_N_O(rts_n), .IRQ_O(irq)
    );

    ut_remote u_rem (
        .clk_i(clk), .rst_n_i(rst_n), .tick_i(tick), .ovs_i(ovs[4:0]),
        .len_i(len[3:0]), .par_i(par), .line_i(txd), .cts_n_i(rts_n),
        .line_o(rem_line)
    );

    // Clock and a tick on every second cycle
    always #10 clk = ~clk;
    always @(posedge clk) tick <= ~tick;

    task automatic give_verdict();
        if (n_fail == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic chk_reg(input logic [3:0] a, input logic [7:0] e,
                           input string nm);
        logic [7:0] v;
        rd_reg(a, v);
        check(nm, v, e);
    endtask

    // Poll data ready, then pop one received byte
    task automatic rx_get(output logic [7:0] v);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 3000 && !s[0]; i++) rd_reg(A_LSR, s);
        check("data ready", {7'h00, s[0]}, 8'h01);
        rd_reg(A_DATA, v);
    endtask

    task automatic rem_get(input logic [7:0] e);
        for (int i = 0; i < 4000 && u_rem.rxq.size() == 0; i++) begin
            @(posedge clk);
        end
        check("remote byte",
              u_rem.rxq.size() > 0 ? u_rem.rxq.pop_front() : 8'hXX, e);
    endtask

    task automatic fmt(input int m, input int l, input logic p,
                       input logic [7:0] x);
        ovs = 16 >> m;
        len = l;
        par = p;
        wr_reg(A_DLD, 8'(m << 4));
        wr_reg(A_LCR, 8'(l - 5) | (p ? 8'h18 : 8'h00) | x);
    endtask

    task automatic t_reset();
        check("rts idle", {7'h00, rts_n}, 8'h01);
        check("txd idle", {7'h00, txd}, 8'h01);
        chk_reg(A_LSR, 8'h60, "line status");
        chk_reg(A_ISR, 8'h01, "int status");
        chk_reg(4'hF, 8'h00, "unmapped");
        wr_reg(A_MCR, 8'h02);
        @(posedge clk);
        check("rts on", {7'h00, rts_n}, 8'h00);
    endtask

    // Every sampling mode and word length, parity and two stops mixed in
    task automatic t_tx_modes();
        logic [7:0] s;
        logic [7:0] b;
        for (int m = 0; m < 4; m++) begin
            fmt(m % 3, 8 - m, m[0], m == 2 ? 8'h04 : 8'h00);
            b = 8'h5A ^ 8'(m);
            wr_reg(A_DATA, b);
            rd_reg(A_LSR, s);
            check("shifter busy", s & 8'h40, 8'h00);
            rem_get(b & ~(8'hFF << (8 - m)));
            repeat (2 * ovs + 8) @(posedge clk);
            chk_reg(A_LSR, 8'h60, "tx idle");
        end
    endtask

    task automatic t_fifo_tx();
        fmt(0, 8, 1'b0, 8'h00);
        wr_reg(A_FCR, 8'h01);
        wr_reg(A_IER, 8'h02);
        for (int i = 0; i < 3; i++) wr_reg(A_DATA, 8'h31 + 8'(i));
        chk_reg(A_LSR, 8'h00, "queue busy");
        for (int i = 0; i < 3; i++) rem_get(8'h31 + 8'(i));
        check("tx irq", {7'h00, irq}, 8'h01);
        chk_reg(A_ISR, 8'h02, "tx flag");
        wr_reg(A_IER, 8'h00);
    endtask

    task automatic t_cts();
        logic [7:0] s;
        wr_reg(A_EFR, 8'h90);
        wr_reg(A_IER, 8'h80);
        wr_reg(A_DATA, 8'h41);
        wr_reg(A_DATA, 8'h42);
        for (int i = 0; i < 400 && txd; i++) @(posedge clk);
        cts_n <= 1'b1;
        rd_reg(A_ISR, s);
        check("cts flag", s & 8'h20, 8'h20);
        rem_get(8'h41);
        wr_reg(A_DATA, 8'h43);
        repeat (800) @(posedge clk);
        check("tx held", 8'(u_rem.rxq.size()), 8'h00);
        chk_reg(A_LSR, 8'h00, "queue kept");
        @(posedge clk);
        cts_n <= 1'b0;
        rem_get(8'h42);
        rem_get(8'h43);
        wr_reg(A_EFR, 8'h00);
    endtask

    task automatic t_rx();
        logic [7:0] b;
        wr_reg(A_FCR, 8'h00);
        wr_reg(A_IER, 8'h01);
        glitch <= 1'b1;
        repeat (4) @(posedge clk);
        glitch <= 1'b0;
        repeat (800) @(posedge clk);
        chk_reg(A_LSR, 8'h60, "false start");
        u_rem.txq.push_back(9'h0C3);
        for (int i = 0; i < 1000 && !irq; i++) @(posedge clk);
        check("rx irq", {7'h00, irq}, 8'h01);
        rx_get(b);
        check("rx byte", b, 8'hC3);
        repeat (2) @(posedge clk);
        check("irq off", {7'h00, irq}, 8'h00);
    endtask

    // Bad parity on the first byte, tags follow the head
    task automatic t_err();
        logic [7:0] b;
        wr_reg(A_FCR, 8'h01);
        fmt(0, 8, 1'b1, 8'h00);
        u_rem.txq.push_back(9'h155);
        u_rem.txq.push_back(9'h0AA);
        repeat (800) @(posedge clk);
        chk_reg(A_LSR, 8'h65, "parity tag");
        rx_get(b);
        check("bad byte", b, 8'h55);
        chk_reg(A_LSR, 8'h61, "next tag");
        rx_get(b);
        check("good byte", b, 8'hAA);
    endtask

    // One byte below trigger: 704 ticks after the push
    task automatic t_timeout();
        logic [7:0] s;
        fmt(0, 8, 1'b0, 8'h00);
        u_rem.txq.push_back(9'h07E);
        for (int i = 0; i < 400 && rem_line; i++) @(posedge clk);
        repeat (1640) @(posedge clk);
        check("early timeout", {7'h00, irq}, 8'h00);
        repeat (140) @(posedge clk);
        check("timeout irq", {7'h00, irq}, 8'h01);
        rd_reg(A_ISR, s);
        check("timeout flag", s & 8'h09, 8'h08);
        rx_get(s);
        check("held byte", s, 8'h7E);
    endtask

    task automatic t_rts(input logic [7:0] f, input int hi, input int lo);
        logic [7:0] s;
        logic [7:0] b;
        wr_reg(A_FCR, f);
        wr_reg(A_EFR, 8'h50);
        wr_reg(A_IER, 8'h40);
        for (int i = 0; i < hi + 4; i++) u_rem.txq.push_back(9'(i));
        for (int i = 0; i < 25000 && !rts_n; i++) @(posedge clk);
        rd_reg(A_ISR, s);
        check("rts flag", s & 8'h20, 8'h20);
        repeat (800) @(posedge clk);
        check("held", 8'(u_rem.txq.size()), 8'h04);
        for (int i = 0; i < hi + 4; i++) begin
            rx_get(b);
            check("rx order", b, 8'(i));
            if (i == hi - lo - 2 || i == hi - lo - 1) begin
                repeat (2) @(posedge clk);
                check("rts level", {7'h00, rts_n},
                      8'(i == hi - lo - 2));
            end
        end
        wr_reg(A_IER, 8'h00);
    endtask

    // Hang guard
    initial begin
        #(90000 * 20);
        n_fail++;
        give_verdict();
    end

    // Main sequence
    initial begin
        clk = 1'b0;
        tick = 1'b0;
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        cts_n = 1'b0;
        glitch = 1'b0;
        ovs = 16;
        len = 8;
        par = 1'b0;
        n_fail = 0;
        tests_run = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_reset();
        t_tx_modes();
        t_fifo_tx();
        t_cts();
        t_rx();
        t_err();
        t_timeout();
        t_rts(8'h01, 16, 0);
        t_rts(8'h41, 56, 8);
        t_rts(8'h81, 60, 16);
        give_verdict();
    end
endmodule
